// [bench/gic_controller_properties.sv]
// gic_controller_properties: port assertions of the controller
// assumes one clock domain, bound from the bench top
`timescale 1ns/1ps
module gic_controller_properties
  import gic_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire gic_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire gic_rate_t    rate,
  input wire logic         normal_mode,
  input wire gic_pin_t     irq_pin_a,
  input wire gic_pin_t     irq_pin_b
);
  logic [3:0] cfg;
  logic [2:0] wr_h;
  logic       act_a;
  logic       act_b;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of pin config and recent writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg  <= 4'h0;
      wr_h <= 3'h0;
    end else begin
      wr_h <= {wr_h[1:0], reg_req.wr};
      if (reg_req.wr && reg_req.addr == ADDR_PIN_CFG) begin
        cfg <= reg_req.wdata[3:0];
      end
    end
  end
  assign act_a = irq_pin_a.oe && irq_pin_a.out == cfg[PA_LVL_BIT];
  assign act_b = irq_pin_b.oe && irq_pin_b.out == cfg[PB_LVL_BIT];
  property p_pa_od;
    $stable(cfg) && cfg[PA_OD_BIT] |->
      !irq_pin_a.oe || irq_pin_a.out == cfg[PA_LVL_BIT];
  endproperty
  a_pa_od: assert property (p_pa_od) else $error("pin a od");
  property p_pa_pp;
    $stable(cfg) && !cfg[PA_OD_BIT] |-> irq_pin_a.oe;
  endproperty
  a_pa_pp: assert property (p_pa_pp) else $error("pin a pp");
  property p_pb_drv;
    $stable(cfg) |-> (cfg[PB_OD_BIT] ?
      (!irq_pin_b.oe || irq_pin_b.out == cfg[PB_LVL_BIT]) : irq_pin_b.oe);
  endproperty
  a_pb_drv: assert property (p_pb_drv) else $error("pin b drv");
  property p_cfg_rd;
    reg_req.rd && reg_req.addr == ADDR_PIN_CFG |=>
      reg_rdata[3:0] == $past(cfg);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("cfg read");
  property p_clr_rd;
    reg_req.rd && reg_req.addr == ADDR_MODE |=> !reg_rdata[CLR_CMD_BIT];
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clr bit");
  property p_idle_rd;
    !reg_req.rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("rdata");
  property p_rise_a;
    $rose(act_a) && wr_h == 3'h0 |-> $past(rate.strobe, 2);
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("rise a");
  property p_rise_b;
    $rose(act_b) && wr_h == 3'h0 |-> $past(normal_mode, 2);
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("rise b");
endmodule : gic_controller_properties

// [bench/gic_controller_tb.sv]
// gic_controller_tb: self-checking bench of the controller
// assumes shortened timer parameters
`timescale 1ns/1ps
module gic_controller_tb
  import gic_pkg::*;
;
  function automatic gic_time_tab_t tab();
    gic_time_tab_t t;
    for (int i = 0; i < 12; i++) t[i] = 32'(40 + 4 * i);
    return t;
  endfunction : tab
  function automatic int tidx(int m);
    return (m < 8) ? m - 1 : m - 3;
  endfunction : tidx
  localparam gic_time_tab_t TT  = tab();
  localparam int            NDC = 20;
  logic         clk;
  logic         rst_n;
  gic_reg_req_t req;
  logic [7:0]   rdata;
  gic_rate_t    rate;
  logic         nm;
  logic         aux;
  logic [3:0]   bw;
  gic_pin_t     pa;
  gic_pin_t     pb;
  logic [3:0]   pcfg;
  logic         sa;
  logic         sb;
  logic [7:0]   d;
  logic [7:0]   v;
  logic [15:0]  st;
  int           n;
  int           errors;
  int           checks_done;
  logic [5:0]   ra [7] = '{ADDR_ENABLE, ADDR_PIN_CFG, ADDR_MAP_A,
                           ADDR_MAP_B, ADDR_THRESH, ADDR_DUR_AXIS, ADDR_MODE};
  logic [7:0]   rm [7] = '{8'hC0, 8'h0F, 8'h07, 8'h07, 8'hFF, 8'h37, 8'h0F};
  gic_controller #(.NEWDATA_CYCLES(NDC), .SLOPE_CYCLES(8), .TEMP_CYCLES(TT))
    u_dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
           .rate(rate), .bandwidth_code(bw), .normal_mode(nm),
           .aux_condition(aux), .irq_pin_a(pa), .irq_pin_b(pb));
  gic_host_model u_host (.irq_pin_a(pa), .irq_pin_b(pb), .pin_cfg(pcfg),
                         .seen_a(sa), .seen_b(sb));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(logic [5:0] a, logic [7:0] w);
    @(posedge clk) req <= '{1'b1, 1'b0, a, w};
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(logic [5:0] a);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    @(negedge clk) d = rdata;
    @(posedge clk);
  endtask : rd
  task automatic stb(logic [15:0] x, logic [15:0] y);
    @(posedge clk) rate <= '{1'b1, x, y, 16'h0000};
    @(posedge clk) rate.strobe <= 1'b0;
  endtask : stb
  task automatic ramp(logic [15:0] sx, logic [15:0] sy, logic e);
    repeat (64) @(posedge clk) rate <= '{1'b0, rate.x + sx, rate.y + sy, 16'h0};
    stb(rate.x + sx, rate.y + sy);
    rd(ADDR_STATUS);
    chk(8'(d[ST_SLOPE_BIT]), 8'(e));
  endtask : ramp
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    {req, rate, aux, bw, pcfg, errors, checks_done} = '0;
    nm = 1'b1;
    rst_n = 1'b0;
    void'($urandom(32'h03CD));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, REG_RESET);
      v = 8'($urandom);
      wr(ra[i], v);
      rd(ra[i]);
      chk(d & rm[i], v & rm[i]);
    end
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS);
    chk(d, 8'h00);
    pcfg = 4'h1;
    wr(ADDR_PIN_CFG, 8'h01);
    wr(ADDR_MAP_A, 8'h01);
    wr(ADDR_MAP_B, 8'h00);
    wr(ADDR_DUR_AXIS, 8'h00);
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_ENABLE, 8'h80);
    stb(16'h0, 16'h0);
    n = 0;
    repeat (2 * NDC) @(negedge clk) n += int'(sa);
    chk(8'(n), 8'(NDC));
    stb(16'h0, 16'h0);
    rd(ADDR_STATUS);
    chk(8'(d[ST_NEWDATA_BIT]), 8'h01);
    wr(ADDR_ENABLE, 8'h00);
    @(posedge clk);
    rd(ADDR_STATUS);
    chk(d, 8'h00);
    pcfg = 4'hB;
    wr(ADDR_PIN_CFG, 8'h0B);
    wr(ADDR_MAP_B, 8'h04);
    wr(ADDR_ENABLE, 8'h40);
    for (int m = 0; m < 16; m++) begin
      wr(ADDR_MODE, 8'(m));
      aux <= 1'b1;
      stb(16'h0, 16'h0);
      aux <= 1'b0;
      stb(16'h0, 16'h0);
      rd(ADDR_STATUS);
      chk(8'(d[ST_AUX_BIT]), 8'(m % 8 != 0));
      chk(8'({sa, sb}), 8'(m % 8 != 0));
      if (m % 8 == 7) begin
        aux <= 1'b1;
        wr(ADDR_MODE, 8'(m) | 8'h80);
        stb(16'h0, 16'h0);
        rd(ADDR_STATUS);
        chk(8'(d[ST_AUX_BIT]), 8'h01);
        aux <= 1'b0;
        wr(ADDR_MODE, 8'(m) | 8'h80);
      end else if (m % 8 != 0) begin
        repeat (TT[tidx(m)] - 8) @(posedge clk);
        rd(ADDR_STATUS);
        chk(8'(d[ST_AUX_BIT]), 8'h01);
      end else begin
        nm <= 1'b0;
        aux <= 1'b1;
        stb(16'h0, 16'h0);
        nm <= 1'b1;
        aux <= 1'b0;
      end
      rd(ADDR_STATUS);
      chk(d, 8'h00);
    end
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MAP_A, 8'h02);
    wr(ADDR_THRESH, 8'h02);
    wr(ADDR_DUR_AXIS, 8'h01);
    st = 16'(1000 + $urandom % 1000);
    ramp(16'h0, st, 1'b0);
    ramp(st, 16'h0, 1'b1);
    chk(8'(sa), 8'h01);
    ramp(16'h0, 16'h0, 1'b0);
    bw <= 4'h5;
    ramp(st, 16'h0, 1'b0);
    bw <= 4'h0;
    ramp(16'h4, 16'h0, 1'b0);
    ramp(16'h5, 16'h0, 1'b1);
    complete_run();
  end
endmodule : gic_controller_tb
bind gic_controller gic_controller_properties u_props (
  .clk        (clk),
  .rst_n      (rst_n),
  .reg_req    (reg_req),
  .reg_rdata  (reg_rdata),
  .rate       (rate),
  .normal_mode(normal_mode),
  .irq_pin_a  (irq_pin_a),
  .irq_pin_b  (irq_pin_b)
);

// [bench/gic_host_model.sv]
// gic_host_model: host side of the two irq wires
// assumes a pull resistor to the inactive level on each wire
`timescale 1ns/1ps
module gic_host_model
  import gic_pkg::*;
(
  input  wire gic_pin_t   irq_pin_a,
  input  wire gic_pin_t   irq_pin_b,
  input  wire logic [3:0] pin_cfg,
  output logic            seen_a,
  output logic            seen_b
);
  logic wire_a;
  logic wire_b;
  // released wire goes to the pulled level
  assign wire_a = irq_pin_a.oe ? irq_pin_a.out : !pin_cfg[PA_LVL_BIT];
  assign wire_b = irq_pin_b.oe ? irq_pin_b.out : !pin_cfg[PB_LVL_BIT];
  assign seen_a = wire_a == pin_cfg[PA_LVL_BIT];
  assign seen_b = wire_b == pin_cfg[PB_LVL_BIT];
endmodule : gic_host_model

// [logic/gic_controller.sv]
// gic_controller: interrupt controller of a three-axis rate sensor.
// assumes rate samples and register requests synchronous to clk.
`timescale 1ns/1ps
module gic_controller
  import gic_pkg::*;
#(
  parameter int            NEWDATA_CYCLES = NEWDATA_CYC,
  parameter int            SLOPE_CYCLES   = SLOPE_CYC,
  parameter gic_time_tab_t TEMP_CYCLES    = TEMP_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire gic_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire gic_rate_t    rate,
  input  wire logic [3:0]   bandwidth_code,
  input  wire logic         normal_mode,
  input  wire logic         aux_condition,
  output gic_pin_t          irq_pin_a,
  output gic_pin_t          irq_pin_b
);

  typedef struct packed {
    logic [7:0]        enable;
    logic [7:0]        pin_cfg;
    logic [7:0]        map_a;
    logic [7:0]        map_b;
    logic [7:0]        thresh;
    logic [7:0]        dur_axis;
    logic [3:0]        mode;
    logic [2:0]        status;
    logic [2:0][31:0]  timer;
    logic [2:0][15:0]  prev;
    logic [4:0]        above_cnt;
    logic [4:0]        below_cnt;
    logic              slope_cond;
    logic [31:0]       tick_cnt;
    logic [7:0]        rdata;
    gic_pin_t          pa;
    gic_pin_t          pb;
  } gic_state_t;

  gic_state_t st;
  gic_state_t next_st;

  logic [2:0][15:0] cur;
  logic [2:0]       axis_over;
  logic [15:0]      thresh_raw;

  assign cur = {rate.z, rate.y, rate.x};
  // 1 dps per lsb at 2000 dps equals about 16.375 raw counts in any range
  assign thresh_raw = {4'h0, st.thresh, 4'h0}
                    + {10'h000, st.thresh[7:2]}
                    + {11'h000, st.thresh[7:3]}; // RULE17

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      logic signed [16:0] diff;
      logic [16:0]        mag;
      assign diff = 17'(signed'(cur[g])) - 17'(signed'(st.prev[g]));
      assign mag  = diff[16] ? 17'(-diff) : diff; // RULE16
      assign axis_over[g] = st.dur_axis[g]
                          && (mag > {1'b0, thresh_raw}); // RULE16
    end
  endgenerate

  function automatic gic_mode_t decode_mode(logic [3:0] code);
    gic_mode_t m;
    case (code[2:0]) // RULE5
      3'h0:    m = GIC_NONLATCH;
      3'h7:    m = GIC_LATCH;
      default: m = GIC_TEMP;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic [3:0] temp_index(logic [3:0] code);
    logic [3:0] idx;
    idx = code[3] ? code - 4'h3 : code - 4'h1; // RULE5
    return idx;
  endfunction : temp_index

  gic_mode_t   mode;
  logic [31:0] temp_cycles;
  logic        slope_tick;
  logic        update;
  logic        clear_cmd;
  logic [2:0]  cond;
  logic [2:0]  en;
  logic [4:0]  need_n;
  logic        act_a;
  logic        act_b;

  assign mode        = decode_mode(st.mode);
  assign temp_cycles = (mode == GIC_TEMP) ? TEMP_CYCLES[temp_index(st.mode)]
                                          : 32'h0; // RULE10
  assign update      = rate.strobe && normal_mode; // RULE3 RULE21
  assign clear_cmd   = reg_req.wr && reg_req.addr == ADDR_MODE
                    && reg_req.wdata[CLR_CMD_BIT]; // RULE8
  assign need_n      = {1'b0, st.dur_axis[DUR_LSB+1:DUR_LSB], 2'b00}
                     + 5'h04; // RULE19
  // capped bandwidth settings use a fixed 625 us slope spacing
  assign slope_tick  = (bandwidth_code <= BW_CAPPED_MAX)
                     ? (st.tick_cnt == 32'(SLOPE_CYCLES - 1))
                     : rate.strobe; // RULE18

  assign en[SRC_NEWDATA] = st.enable[EN_NEWDATA_BIT]; // RULE15
  assign en[SRC_SLOPE]   = |st.dur_axis[2:0]; // RULE20
  assign en[SRC_AUX]     = st.enable[EN_AUX_BIT]; // RULE1
  assign cond[SRC_NEWDATA] = rate.strobe; // RULE14
  assign cond[SRC_SLOPE]   = st.slope_cond;
  assign cond[SRC_AUX]     = aux_condition;

  assign act_a = |(st.status & st.map_a[2:0]); // RULE2 RULE11
  assign act_b = |(st.status & st.map_b[2:0]); // RULE2 RULE11

  always_comb begin
    next_st = st;

    // slope sampling clock
    if (slope_tick || bandwidth_code > BW_CAPPED_MAX) begin
      next_st.tick_cnt = '0;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h1;
    end

    if (slope_tick && normal_mode) begin
      next_st.prev = cur; // RULE16
      if (|axis_over) begin // RULE20
        next_st.below_cnt = '0;
        if (st.above_cnt < need_n) begin
          next_st.above_cnt = st.above_cnt + 5'h01;
        end
        if (st.above_cnt + 5'h01 >= need_n) begin
          next_st.slope_cond = 1'b1; // RULE19
        end
      end else begin
        next_st.above_cnt = '0;
        if (st.below_cnt < need_n) begin
          next_st.below_cnt = st.below_cnt + 5'h01;
        end
        if (st.below_cnt + 5'h01 >= need_n) begin
          next_st.slope_cond = 1'b0; // RULE19 RULE20
        end
      end
    end

    // clear paths first, then set so a set in the same cycle wins; the disable clear comes last
    for (int i = 0; i < 3; i++) begin
      if (st.timer[i] != 32'h0) begin
        next_st.timer[i] = st.timer[i] - 32'h1;
      end
      if (i == SRC_NEWDATA) begin
        if (st.status[i] && st.timer[i] == 32'h1) begin
          next_st.status[i] = 1'b0; // RULE7 RULE14
        end
      end else begin
        case (mode)
          GIC_NONLATCH: begin
            if (update && !cond[i]) begin
              next_st.status[i] = 1'b0; // RULE7 RULE6
            end
          end
          GIC_TEMP: begin
            if (st.status[i] && st.timer[i] == 32'h0 && !cond[i]) begin
              next_st.status[i] = 1'b0; // RULE10 RULE6
            end
          end
          GIC_LATCH: begin
            if (clear_cmd && !cond[i]) begin
              next_st.status[i] = 1'b0; // RULE8 RULE6
            end else if (clear_cmd) begin
              next_st.status[i] = 1'b0; // RULE9
            end
          end
          default: begin
            next_st.status[i] = 1'b0;
          end
        endcase
      end
      if (update && en[i] && cond[i]) begin
        next_st.status[i] = 1'b1; // RULE1 RULE3 RULE9
        if (i == SRC_NEWDATA) begin
          next_st.timer[i] = 32'(NEWDATA_CYCLES); // RULE14
        end else if (!st.status[i] || mode == GIC_TEMP) begin
          next_st.timer[i] = temp_cycles; // RULE10
        end
      end
      if (!en[i]) begin
        next_st.status[i] = 1'b0; // RULE4
        next_st.timer[i]  = '0;
      end
    end

    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_ENABLE:   next_st.enable   = reg_req.wdata;
        ADDR_PIN_CFG:  next_st.pin_cfg  = reg_req.wdata;
        ADDR_MAP_A:    next_st.map_a    = reg_req.wdata; // RULE11
        ADDR_MAP_B:    next_st.map_b    = reg_req.wdata; // RULE11
        ADDR_THRESH:   next_st.thresh   = reg_req.wdata;
        ADDR_DUR_AXIS: next_st.dur_axis = reg_req.wdata;
        ADDR_MODE:     next_st.mode     = reg_req.wdata[3:0]; // RULE5
        default: begin
        end
      endcase
    end

    // register reads, data valid the cycle after the request
    next_st.rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_STATUS: begin
          next_st.rdata[ST_NEWDATA_BIT] = st.status[SRC_NEWDATA]; // RULE15
          next_st.rdata[ST_SLOPE_BIT]   = st.status[SRC_SLOPE];
          next_st.rdata[ST_AUX_BIT]     = st.status[SRC_AUX];
        end
        ADDR_ENABLE:   next_st.rdata = st.enable;
        ADDR_PIN_CFG:  next_st.rdata = st.pin_cfg;
        ADDR_MAP_A:    next_st.rdata = st.map_a;
        ADDR_MAP_B:    next_st.rdata = st.map_b;
        ADDR_THRESH:   next_st.rdata = st.thresh;
        ADDR_DUR_AXIS: next_st.rdata = st.dur_axis;
        ADDR_MODE:     next_st.rdata = {4'h0, st.mode}; // RULE22
        default:       next_st.rdata = '0;
      endcase
    end

    // pin drivers
    if (st.pin_cfg[PA_OD_BIT]) begin
      next_st.pa.oe  = act_a; // RULE13 RULE23
      next_st.pa.out = st.pin_cfg[PA_LVL_BIT];
    end else begin
      next_st.pa.oe  = 1'b1; // RULE13
      next_st.pa.out = act_a ? st.pin_cfg[PA_LVL_BIT]
                             : !st.pin_cfg[PA_LVL_BIT]; // RULE12 RULE23
    end
    if (st.pin_cfg[PB_OD_BIT]) begin
      next_st.pb.oe  = act_b; // RULE13 RULE23
      next_st.pb.out = st.pin_cfg[PB_LVL_BIT];
    end else begin
      next_st.pb.oe  = 1'b1; // RULE13
      next_st.pb.out = act_b ? st.pin_cfg[PB_LVL_BIT]
                             : !st.pin_cfg[PB_LVL_BIT]; // RULE12 RULE23
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st          <= '0;
      st.enable   <= REG_RESET;
      st.pin_cfg  <= REG_RESET;
      st.map_a    <= REG_RESET;
      st.map_b    <= REG_RESET;
      st.thresh   <= REG_RESET;
      st.dur_axis <= REG_RESET;
      st.pa       <= '{out: 1'b1, oe: 1'b1};
      st.pb       <= '{out: 1'b1, oe: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq_pin_a = st.pa;
  assign irq_pin_b = st.pb;

endmodule : gic_controller

// [logic/gic_pkg.sv]
// gic_pkg: constants, register map and carrier types of the rate-sensor
// interrupt controller; assumes a 250 MHz core clock.
//
// Behaviour
// [RULE1] three engines, each enabled alone, set status and drive mapped pin
// [RULE2] each pin is the OR of all active sources mapped to it
// [RULE3] status bits re-evaluated only when a new rate sample word lands
// [RULE4] disabling a source clears its status at once
// [RULE5] common 4-bit mode: non-latched, latched or one of twelve temporary times
// [RULE6] an interrupt cannot be cleared while its condition still holds; code still clears latched status on the clear command
// [RULE7] non-latched clears when condition drops; new-data clears on its own timer
// [RULE8] latched status holds until host writes one to the clear command bit
// [RULE9] latched clear with condition still true re-asserts at next sample
// [RULE10] temporary mode clears status once selected duration has elapsed
// [RULE11] map bits route each source to pin a and/or pin b
// [RULE12] level bit one gives active-high pin, zero active-low
// [RULE13] driver bit one gives open-drain, zero push-pull
// [RULE14] new-data asserts on stored z sample, non-latched, clears after about 300 us
// [RULE15] new-data enable bit and read-only new-data status bit
// [RULE16] slope is absolute difference of successive samples per axis vs threshold
// [RULE17] threshold LSB is 1 dps at 2000 dps range, scaling with range; code uses the 2000 dps scale in every range
// [RULE18] slope samples spaced a quarter update period, capped at 400 Hz; code uses every rate strobe, or 625 us for bandwidth codes up to 2
// [RULE19] assert or clear after N=4*(dur+1) consecutive samples above or below
// [RULE20] any enabled axis triggers; clear needs all enabled axes below threshold
// [RULE21] interrupt updates only run in normal power mode
// [RULE22] clear command bit is write-only and reads zero
// [RULE23] idle pin shows inactive level in push-pull, released in open-drain
package gic_pkg;

  localparam int          CLK_MHZ       = 250;
  localparam logic [5:0]  ADDR_STATUS   = 6'h0A;
  localparam logic [5:0]  ADDR_ENABLE   = 6'h15;
  localparam logic [5:0]  ADDR_PIN_CFG  = 6'h16;
  localparam logic [5:0]  ADDR_MAP_A    = 6'h17;
  localparam logic [5:0]  ADDR_MAP_B    = 6'h19;
  localparam logic [5:0]  ADDR_THRESH   = 6'h1B;
  localparam logic [5:0]  ADDR_DUR_AXIS = 6'h1C;
  localparam logic [5:0]  ADDR_MODE     = 6'h21;

  // source index inside status, enable and map vectors
  localparam int SRC_NEWDATA = 0;
  localparam int SRC_SLOPE   = 1;
  localparam int SRC_AUX     = 2;
  // status and enable register bit positions
  localparam int ST_NEWDATA_BIT = 7;
  localparam int ST_SLOPE_BIT   = 2;
  localparam int ST_AUX_BIT     = 1;
  localparam int EN_NEWDATA_BIT = 7;
  localparam int EN_AUX_BIT     = 6;
  // pin config bit positions
  localparam int PA_LVL_BIT = 0;
  localparam int PA_OD_BIT  = 1;
  localparam int PB_LVL_BIT = 2;
  localparam int PB_OD_BIT  = 3;
  // duration / axis register field and mode register clear command bit
  localparam int DUR_LSB    = 4;
  localparam int CLR_CMD_BIT = 7;

  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] BW_CAPPED_MAX = 4'h2;

  localparam int NEWDATA_US     = 300;
  localparam int SLOPE_SPACE_US = 625;
  localparam int NEWDATA_CYC    = NEWDATA_US * CLK_MHZ;
  localparam int SLOPE_CYC      = SLOPE_SPACE_US * CLK_MHZ;

  typedef logic [11:0][31:0] gic_time_tab_t;
  // temporary durations in us, index 0 holds mode code 1
  localparam gic_time_tab_t TEMP_US = {
    32'd50000, 32'd25000, 32'd12500, 32'd1000, 32'd500, 32'd250,
    32'd8000000, 32'd4000000, 32'd2000000, 32'd1000000,
    32'd500000, 32'd250000};

  function automatic gic_time_tab_t gic_to_cycles(gic_time_tab_t us);
    gic_time_tab_t r;
    r = '0;
    for (int i = 0; i < 12; i++) begin
      r[i] = 32'(longint'(us[i]) * CLK_MHZ);
    end
    return r;
  endfunction : gic_to_cycles

  localparam gic_time_tab_t TEMP_CYC = gic_to_cycles(TEMP_US);

  typedef enum logic [1:0] {
    GIC_NONLATCH = 2'b00,
    GIC_TEMP     = 2'b01,
    GIC_LATCH    = 2'b11
  } gic_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } gic_reg_req_t;

  typedef struct packed {
    logic        strobe;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gic_rate_t;

  typedef struct packed {
    logic out;
    logic oe;
  } gic_pin_t;

endpackage : gic_pkg
